//--- hw/spsm_defs.vh
`ifndef SPSM_DEFS_VH
`define SPSM_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPSM_REG_CTRL       4'h0
`define SPSM_REG_STATE      4'h1
`define SPSM_REG_WAKE_EN    4'h2
`define SPSM_REG_IRQ_STAT   4'h3
`define SPSM_REG_IRQ_CLR    4'h4
`define SPSM_REG_IRQ_EN     4'h5
`define SPSM_REG_CLK_DIV    4'h6

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPSM_CTRL_TARGET_LSB 0
`define SPSM_CTRL_TARGET_MSB 1
`define SPSM_CTRL_RET_LOW    2
`define SPSM_CTRL_LEVEL_WAKE 3
`define SPSM_CTRL_RESET      8'h00

// ----------------------------------------------------------------
// Target sleep encodings
// ----------------------------------------------------------------
`define SPSM_TGT_HALT        2'h0
`define SPSM_TGT_DS_RTC      2'h1
`define SPSM_TGT_DS_NORTC    2'h2

// ----------------------------------------------------------------
// Wake enable fields: periph, timer, rtc, gpio edge, gpio level, cmp
// ----------------------------------------------------------------
`define SPSM_WK_PERIPH       0
`define SPSM_WK_TIMER        1
`define SPSM_WK_RTC          2
`define SPSM_WK_GEDGE        3
`define SPSM_WK_GLEVEL       4
`define SPSM_WK_CMP          5
`define SPSM_WAKE_EN_RESET   6'h3F

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define SPSM_IRQ_WAKE        0
`define SPSM_IRQ_RTC_LOCK    1
`define SPSM_IRQ_ENTER       2

// ----------------------------------------------------------------
// Clock divider for the run and low power compute sub-states
// ----------------------------------------------------------------
`define SPSM_CLK_DIV_RESET   8'h00
`define SPSM_LPC_DIV_MIN     8'h08

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPSM_CLK_HZ          25000000
`define SPSM_ENTRY_CYC       6
`define SPSM_EXIT_CYC        3
`define SPSM_RTC_LOCK_MS     350

`endif

//--- hw/spsm_sync.v
// ----------------------------------------------------------------
// Three-stage synchroniser; a change counts when stages two and three agree.
// ----------------------------------------------------------------
module spsm_sync #(
	parameter W = 1
) (
	input  wire         clk_sys,
	input  wire         rst,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;

	always @(posedge clk_sys) begin
		if (rst) begin
			s1       <= {W{1'b0}};
			s2       <= {W{1'b0}};
			s3       <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			s1       <= async_in;
			s2       <= s1;
			s3       <= s2;
			sync_out <= (s2 & s3) | (sync_out & (s2 | s3));
		end
	end
endmodule // spsm_sync

//--- hw/spsm_lock_timer.v
// ----------------------------------------------------------------
// Counts the oscillator start-up time after a restart request.
// ----------------------------------------------------------------
module spsm_lock_timer #(
	parameter CYCLES = 8750000
) (
	input  wire clk_sys,
	input  wire rst,
	input  wire restart,
	input  wire osc_on,
	output reg  locked,
	output reg  lock_pulse
);
	reg [31:0] cnt;

	always @(posedge clk_sys) begin
		if (rst) begin
			cnt        <= 32'h00000000;
			locked     <= 1'b1;
			lock_pulse <= 1'b0;
		end else begin
			lock_pulse <= 1'b0;
			if (!osc_on || restart) begin
				cnt    <= 32'h00000000;
				locked <= 1'b0;
			end else if (!locked) begin
				if (cnt >= CYCLES - 1) begin
					locked     <= 1'b1;
					lock_pulse <= 1'b1;
				end else begin
					cnt <= cnt + 32'h00000001;
				end
			end
		end
	end
endmodule // spsm_lock_timer

//--- hw/spsm_power_manager.v
// Function
// - Run sub-state keeps regulator normal and clock 4 to 32 MHz, CPU executing.
// - Low power compute runs the clock below 4 MHz, CPU executing, regulator normal.
// - Low power compute takes its clock from the hybrid oscillator at 4 MHz.
// - Halt instruction stops the processor; enabled peripherals keep running.
// - In halt any enabled peripheral interrupt returns the system to active.
// - Both deep sleeps hold the regulator in retention at 1.8 V or 1.35 V.
// - Deep sleep with RTC keeps RTC oscillator on, hybrid oscillator and converter off.
// - Deep sleep with RTC wakes on timer, RTC, GPIO or comparators only.
// - Deep sleep without RTC turns RTC oscillator off; no RTC or timer wake.
// - Deep sleep without RTC disables GPIO debouncing.
// - Deep sleep without RTC gates all clocks; GPIO edge wakes ignored.
// - Deep sleep without RTC wakes only on GPIO level or comparator events.
// - Restarted RTC oscillator is not locked until about 350 ms have passed.
//
// Implementation choices: strobed register access and the register offsets.
`include "spsm_defs.vh"

module spsm_power_manager #(
	parameter RTC_LOCK_CYC = `SPSM_RTC_LOCK_MS * (`SPSM_CLK_HZ / 1000)
) (
	input  wire       clk_sys,
	input  wire       rst,
	input  wire [3:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       halt_exec,
	input  wire       periph_irq,
	input  wire       timer_wake,
	input  wire       rtc_wake,
	input  wire       gpio_edge_wake,
	input  wire       gpio_level_wake,
	input  wire       cmp_wake,
	output reg        cpu_run,
	output reg        reg_normal_mode,
	output reg        reg_ret_low,
	output reg        hyb_osc_on,
	output reg        hyb_si_4mhz,
	output reg        rtc_osc_on,
	output reg        rtc_clk_locked,
	output reg        converter_on,
	output reg        gpio_debounce_en,
	output reg        sram_standby,
	output reg        bus_clk_on,
	output reg        clocks_gated,
	output reg        low_power_compute,
	output reg  [7:0] sys_clk_div,
	output reg        irq
);
	// ----------------------------------------------------------------
	// States.
	// ----------------------------------------------------------------
	localparam [2:0] ST_RUN   = 3'd0;
	localparam [2:0] ST_ENTER = 3'd1;
	localparam [2:0] ST_HALT  = 3'd2;
	localparam [2:0] ST_DSRTC = 3'd3;
	localparam [2:0] ST_DSNO  = 3'd4;
	localparam [2:0] ST_EXIT  = 3'd5;
	localparam integer ENTRY_LOAD = `SPSM_ENTRY_CYC - 2;
	localparam integer EXIT_LOAD  = `SPSM_EXIT_CYC - 2;

	// ----------------------------------------------------------------
	// Decoding shared by several outputs.
	// ----------------------------------------------------------------
	function is_deep;
		input [2:0] st;
		begin
			is_deep = (st == ST_DSRTC) || (st == ST_DSNO);
		end
	endfunction

	function is_asleep;
		input [2:0] st;
		begin
			is_asleep = (st == ST_HALT) || is_deep(st);
		end
	endfunction

	function lpc_rate;
		input [7:0] div;
		begin
			lpc_rate = (div >= `SPSM_LPC_DIV_MIN);
		end
	endfunction

	reg  [2:0] state;
	reg  [2:0] next_state;
	reg  [2:0] cnt;
	reg  [2:0] next_cnt;
	reg  [7:0] ctrl;
	reg  [5:0] wake_en;
	reg  [2:0] irq_stat;
	reg  [2:0] irq_en;
	reg  [7:0] clk_div;
	reg        left_nortc;
	wire [4:0] ext_sync;
	wire       rtc_locked;
	wire       rtc_lock_pulse;
	wire [1:0] target;
	wire       wake_halt;
	wire       wake_dsrtc;
	wire       wake_dsno;
	wire       wake_now;
	wire       entered;
	wire [2:0] clr_bits;
	wire       going_deep;
	wire       going_asleep;
	wire       lpc_now;

	assign target = ctrl[`SPSM_CTRL_TARGET_MSB:`SPSM_CTRL_TARGET_LSB];
	assign going_deep   = is_deep(next_state);
	assign going_asleep = is_asleep(next_state);
	assign lpc_now      = lpc_rate(clk_div);

	// ----------------------------------------------------------------
	// Pin wake sources come from other domains and are synchronised.
	// ----------------------------------------------------------------
	spsm_sync #(
		.W (5)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({cmp_wake, gpio_level_wake, gpio_edge_wake, rtc_wake, timer_wake}),
		.sync_out (ext_sync)
	);

	// ----------------------------------------------------------------
	// Wake qualification per state.
	// ----------------------------------------------------------------
	assign wake_halt = periph_irq & wake_en[`SPSM_WK_PERIPH];

	assign wake_dsrtc = (ext_sync[0] & wake_en[`SPSM_WK_TIMER]) |
	                    (ext_sync[1] & wake_en[`SPSM_WK_RTC]) |
	                    (ext_sync[2] & wake_en[`SPSM_WK_GEDGE]) |
	                    (ext_sync[3] & wake_en[`SPSM_WK_GLEVEL]) |
	                    (ext_sync[4] & wake_en[`SPSM_WK_CMP]);

	// Timer, RTC and edge wakes never count here; level wake follows a control bit.
	assign wake_dsno = (ext_sync[3] & wake_en[`SPSM_WK_GLEVEL] & ctrl[`SPSM_CTRL_LEVEL_WAKE]) |
	                   (ext_sync[4] & wake_en[`SPSM_WK_CMP]);

	assign wake_now = (state == ST_HALT  && wake_halt) ||
	                  (state == ST_DSRTC && wake_dsrtc) ||
	                  (state == ST_DSNO  && wake_dsno);

	assign entered = (state == ST_ENTER) && (cnt == 3'd0);

	// ----------------------------------------------------------------
	// State machine.
	// ----------------------------------------------------------------
	always @* begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
			ST_RUN: begin
				if (halt_exec) begin
					next_state = ST_ENTER;
					next_cnt   = ENTRY_LOAD[2:0];
				end
			end
			ST_ENTER: begin
				if (cnt == 3'd0) begin
					case (target)
						`SPSM_TGT_DS_RTC:   next_state = ST_DSRTC;
						`SPSM_TGT_DS_NORTC: next_state = ST_DSNO;
						default:            next_state = ST_HALT;
					endcase
				end else begin
					next_cnt = cnt - 3'd1;
				end
			end
			ST_HALT, ST_DSRTC, ST_DSNO: begin
				if (wake_now) begin
					next_state = ST_EXIT;
					next_cnt   = EXIT_LOAD[2:0];
				end
			end
			ST_EXIT: begin
				if (cnt == 3'd0) begin
					next_state = ST_RUN;
				end else begin
					next_cnt = cnt - 3'd1;
				end
			end
			default: begin
				next_state = ST_RUN;
				next_cnt   = 3'd0;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			state      <= ST_RUN;
			cnt        <= 3'd0;
			left_nortc <= 1'b0;
		end else begin
			state      <= next_state;
			cnt        <= next_cnt;
			left_nortc <= (state == ST_DSNO) && wake_now;
		end
	end

	// ----------------------------------------------------------------
	// RTC oscillator lock timing after a restart.
	// ----------------------------------------------------------------
	spsm_lock_timer #(
		.CYCLES (RTC_LOCK_CYC)
	) u_lock (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.restart    (left_nortc),
		.osc_on     (state != ST_DSNO),
		.locked     (rtc_locked),
		.lock_pulse (rtc_lock_pulse)
	);

	// ----------------------------------------------------------------
	// Register file.
	// ----------------------------------------------------------------
	assign clr_bits = (reg_wr && reg_addr == `SPSM_REG_IRQ_CLR) ? reg_wdata[2:0] : 3'b000;

	always @(posedge clk_sys) begin
		if (rst) begin
			ctrl      <= `SPSM_CTRL_RESET;
			wake_en   <= `SPSM_WAKE_EN_RESET;
			irq_en    <= 3'b000;
			clk_div   <= `SPSM_CLK_DIV_RESET;
			irq_stat  <= 3'b000;
			reg_rdata <= 8'h00;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
					`SPSM_REG_CTRL:    ctrl    <= reg_wdata;
					`SPSM_REG_WAKE_EN: wake_en <= reg_wdata[5:0];
					`SPSM_REG_IRQ_EN:  irq_en  <= reg_wdata[2:0];
					`SPSM_REG_CLK_DIV: clk_div <= reg_wdata;
					default:           ctrl    <= ctrl;
				endcase
			end
			// Set wins over clear.
			irq_stat <= (irq_stat & ~clr_bits) |
			            {entered, rtc_lock_pulse, (state == ST_EXIT && cnt == 3'd0)};
			reg_rdata <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					`SPSM_REG_CTRL:     reg_rdata <= ctrl;
					`SPSM_REG_STATE:    reg_rdata <= {4'h0, rtc_locked, state};
					`SPSM_REG_WAKE_EN:  reg_rdata <= {2'b00, wake_en};
					`SPSM_REG_IRQ_STAT: reg_rdata <= {5'h00, irq_stat};
					`SPSM_REG_IRQ_EN:   reg_rdata <= {5'h00, irq_en};
					`SPSM_REG_CLK_DIV:  reg_rdata <= clk_div;
					default:            reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Power controls, all registered.
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (rst) begin
			cpu_run           <= 1'b1;
			reg_normal_mode   <= 1'b1;
			reg_ret_low       <= 1'b0;
			hyb_osc_on        <= 1'b1;
			hyb_si_4mhz       <= 1'b0;
			rtc_osc_on        <= 1'b1;
			rtc_clk_locked    <= 1'b1;
			converter_on      <= 1'b1;
			gpio_debounce_en  <= 1'b1;
			sram_standby      <= 1'b0;
			bus_clk_on        <= 1'b1;
			clocks_gated      <= 1'b0;
			low_power_compute <= 1'b0;
			sys_clk_div       <= `SPSM_CLK_DIV_RESET;
			irq               <= 1'b0;
		end else begin
			cpu_run           <= (next_state == ST_RUN);
			reg_normal_mode   <= !going_deep;
			reg_ret_low       <= ctrl[`SPSM_CTRL_RET_LOW];
			hyb_osc_on        <= !going_deep;
			hyb_si_4mhz       <= lpc_now;
			rtc_osc_on        <= (next_state != ST_DSNO);
			rtc_clk_locked    <= rtc_locked && (next_state != ST_DSNO);
			converter_on      <= !going_deep;
			gpio_debounce_en  <= (next_state != ST_DSNO);
			sram_standby      <= going_asleep;
			bus_clk_on        <= !going_deep;
			clocks_gated      <= (next_state == ST_DSNO);
			low_power_compute <= lpc_now;
			sys_clk_div       <= clk_div;
			irq               <= |(irq_stat & irq_en);
		end
	end
endmodule // spsm_power_manager

//--- test/spsm_wake_src.sv
// ----------------------------------------
// Wake source model: raises one line for eight cycles, promptly or late.
// ----------------------------------------
module spsm_wake_src (
	input  logic       clk_sys,
	input  logic       rst,
	input  logic       fire,
	input  logic [2:0] sel,
	input  logic       slow,
	output logic [4:0] wake
);
	timeunit 1ns;
	timeprecision 100ps;
	int         cnt = 0;
	logic [2:0] cur = 3'h0;
	initial wake = 5'h00;
	// Only the one source picked by the bench is raised; the others stay low.
	always @(posedge clk_sys) begin
		if (rst) begin
			cnt  <= 0;
			wake <= 5'h00;
		end else if (fire) begin
			cnt <= slow ? 14 : 9;
			cur <= sel;
		end else if (cnt != 0) begin
			cnt  <= cnt - 1;
			wake <= (cnt > 1 && cnt <= 9) ? (5'h01 << cur) : 5'h00;
		end
	end
endmodule // spsm_wake_src

//--- test/spsm_power_manager_chk.sv
`include "spsm_defs.vh"
module spsm_power_manager_chk #(
	parameter RTC_LOCK_CYC = 40
) (
	input wire       clk_sys,
	input wire       rst,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       halt_exec,
	input wire       periph_irq,
	input wire       cpu_run,
	input wire       reg_normal_mode,
	input wire       hyb_osc_on,
	input wire       hyb_si_4mhz,
	input wire       rtc_osc_on,
	input wire       rtc_clk_locked,
	input wire       converter_on,
	input wire       gpio_debounce_en,
	input wire       sram_standby,
	input wire       bus_clk_on,
	input wire       clocks_gated,
	input wire       low_power_compute,
	input wire [7:0] sys_clk_div,
	input wire       irq
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LOCK_MAX = RTC_LOCK_CYC + 8;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_halt_stops_cpu: assert property (cpu_run && halt_exec |=> !cpu_run)
		else $error("cpu kept running after halt");
	a_halt_entry_time: assert property (cpu_run && halt_exec |-> ##[5:8] sram_standby)
		else $error("sleep not reached in time");
	a_halt_wake_time: assert property (sram_standby && reg_normal_mode && periph_irq |-> ##[1:5] cpu_run)
		else $error("halt wake too slow");
	a_run_power_on: assert property (cpu_run |-> reg_normal_mode && !sram_standby && bus_clk_on)
		else $error("run without normal power");
	a_lpc_clock_src: assert property (low_power_compute == (sys_clk_div >= 8'h08) && hyb_si_4mhz == low_power_compute)
		else $error("low power compute flag wrong");
	a_retention_off: assert property (!reg_normal_mode |-> !hyb_osc_on && !converter_on && !bus_clk_on && sram_standby)
		else $error("deep sleep left clocks on");
	a_rtc_sleep_osc: assert property (!reg_normal_mode && !clocks_gated |-> rtc_osc_on)
		else $error("rtc oscillator off in rtc sleep");
	a_nortc_gating: assert property (clocks_gated |-> !rtc_osc_on && !gpio_debounce_en && !reg_normal_mode)
		else $error("no-rtc sleep state wrong");
	a_rtc_lock_hold: assert property ($rose(rtc_osc_on) |-> !rtc_clk_locked [*8])
		else $error("rtc locked too early");
	a_rtc_lock_time: assert property ($rose(rtc_osc_on) |-> ##[1:LOCK_MAX] rtc_clk_locked)
		else $error("rtc never locked");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	a_irq_mask: assert property (reg_wr && reg_addr == `SPSM_REG_IRQ_EN && reg_wdata == 8'h00 |-> ##[1:2] !irq)
		else $error("masked irq still high");
	c_halt: cover property (cpu_run && halt_exec);
	c_nortc_exit: cover property ($fell(clocks_gated));
	c_lpc: cover property ($rose(low_power_compute));
endmodule // spsm_power_manager_chk
bind spsm_power_manager spsm_power_manager_chk #(.RTC_LOCK_CYC(RTC_LOCK_CYC)) i_spsm_power_manager_chk (
	.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .halt_exec, .periph_irq, .cpu_run,
	.reg_normal_mode, .hyb_osc_on, .hyb_si_4mhz, .rtc_osc_on, .rtc_clk_locked, .converter_on, .gpio_debounce_en,
	.sram_standby, .bus_clk_on, .clocks_gated, .low_power_compute, .sys_clk_div, .irq);

//--- test/spsm_power_manager_tb.sv
`include "spsm_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module spsm_power_manager_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LOCK = 40;
	logic       clk_sys, rst, reg_wr, reg_rd, halt_exec, periph_irq, fire, slow;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, sys_clk_div, ctl;
	logic [2:0] sel;
	logic [4:0] wk;
	logic       cpu_run, reg_normal_mode, reg_ret_low, hyb_osc_on, hyb_si_4mhz, rtc_osc_on, rtc_clk_locked;
	logic       converter_on, gpio_debounce_en, sram_standby, bus_clk_on, clocks_gated, low_power_compute, irq;
	int         bad_count = 0, cmp_count = 0, cycles = 0, n, seed, d, ret;
	int         srcs[$] = '{0, 1, 2, 3, 4};
	spsm_power_manager #(.RTC_LOCK_CYC(LOCK)) i_spsm_power_manager (.clk_sys, .rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .halt_exec, .periph_irq, .timer_wake(wk[0]), .rtc_wake(wk[1]),
		.gpio_edge_wake(wk[2]), .gpio_level_wake(wk[3]), .cmp_wake(wk[4]), .cpu_run, .reg_normal_mode,
		.reg_ret_low, .hyb_osc_on, .hyb_si_4mhz, .rtc_osc_on, .rtc_clk_locked, .converter_on, .gpio_debounce_en,
		.sram_standby, .bus_clk_on, .clocks_gated, .low_power_compute, .sys_clk_div, .irq);
	spsm_wake_src i_spsm_wake_src (.clk_sys, .rst, .fire, .sel, .slow, .wake(wk));
	task automatic final_report();
		$display("Counts: compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic chkrd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] v;
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		v = reg_rdata;
		`CHK(v & m, e)
	endtask
	task automatic enter(input logic [7:0] c);
		wr(`SPSM_REG_CTRL, c);
		@(posedge clk_sys);
		halt_exec <= 1'b1;
		@(posedge clk_sys);
		halt_exec <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic wake(input int s, input logic e);
		int i;
		@(posedge clk_sys);
		fire <= 1'b1;
		sel  <= s[2:0];
		slow <= 1'($urandom % 2);
		@(posedge clk_sys);
		fire <= 1'b0;
		for (i = 0; i < 24 && cpu_run !== 1'b1; i++) @(posedge clk_sys);
		`CHK(cpu_run, e)
		repeat (8) @(posedge clk_sys);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		{rst, reg_addr, reg_wdata, reg_wr, reg_rd, halt_exec, periph_irq, fire, sel, slow} = {1'b1, 21'h0};
		seed = $urandom(2);
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		chkrd(`SPSM_REG_CTRL, 8'hFF, `SPSM_CTRL_RESET);
		chkrd(`SPSM_REG_WAKE_EN, 8'hFF, 8'h3F);
		chkrd(4'hF, 8'hFF, 8'h00);
		`CHK({cpu_run, rtc_clk_locked}, 2'b11)
		$display("test reset done");
		for (n = 0; n < 6; n++) begin
			d = (n < 2) ? 7 + n : $urandom % 256;
			wr(`SPSM_REG_CLK_DIV, d[7:0]);
			repeat (2) @(posedge clk_sys);
			`CHK({sys_clk_div, low_power_compute, cpu_run}, {d[7:0], d >= 8, 1'b1})
			`CHK(hyb_si_4mhz, d >= 8)
		end
		wr(`SPSM_REG_CLK_DIV, 8'h00);
		$display("test clock range done");
		enter({6'h0, `SPSM_TGT_HALT});
		chkrd(`SPSM_REG_STATE, 8'h07, 8'h02);
		`CHK({cpu_run, sram_standby, reg_normal_mode, bus_clk_on}, 4'b0111)
		periph_irq <= 1'b1;
		for (n = 0; n < 10 && cpu_run !== 1'b1; n++) @(posedge clk_sys);
		periph_irq <= 1'b0;
		`CHK(n <= 5, 1'b1)
		chkrd(`SPSM_REG_STATE, 8'h07, 8'h00);
		$display("test halt done");
		foreach (srcs[k]) begin
			ret = (srcs[k] == 2 || srcs[k] == 3) ? 0 : $urandom % 2;
			ctl = {5'h0, ret[0], `SPSM_TGT_DS_RTC};
			enter(ctl);
			chkrd(`SPSM_REG_STATE, 8'h07, 8'h03);
			`CHK({reg_normal_mode, reg_ret_low}, {1'b0, ret[0]})
			`CHK({rtc_osc_on, hyb_osc_on, converter_on}, 3'b100)
			wake(srcs[k], 1'b1);
		end
		wr(`SPSM_REG_WAKE_EN, 8'h1F);
		enter({6'h0, `SPSM_TGT_DS_RTC});
		wake(4, 1'b0);
		wake(0, 1'b1);
		wr(`SPSM_REG_WAKE_EN, 8'h3F);
		$display("test deep sleep rtc done");
		wr(`SPSM_REG_CLK_DIV, `SPSM_LPC_DIV_MIN);
		enter({6'h0, `SPSM_TGT_DS_NORTC});
		chkrd(`SPSM_REG_STATE, 8'h0F, 8'h04);
		`CHK({clocks_gated, rtc_osc_on, gpio_debounce_en}, 3'b100)
		for (n = 0; n < 4; n++) wake(n, 1'b0);
		wake(4, 1'b1);
		`CHK(rtc_clk_locked, 1'b0)
		repeat (LOCK + 10) @(posedge clk_sys);
		`CHK(rtc_clk_locked, 1'b1)
		enter(8'h08 | `SPSM_TGT_DS_NORTC);
		wake(3, 1'b1);
		wr(`SPSM_REG_CLK_DIV, 8'h00);
		$display("test deep sleep no rtc done");
		chkrd(`SPSM_REG_IRQ_STAT, 8'hFF, 8'h07);
		wr(`SPSM_REG_IRQ_EN, 8'h01);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		wr(`SPSM_REG_IRQ_EN, 8'h00);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		wr(`SPSM_REG_IRQ_EN, 8'h07);
		wr(`SPSM_REG_IRQ_CLR, 8'h07);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		chkrd(`SPSM_REG_IRQ_STAT, 8'hFF, 8'h00);
		wr(`SPSM_REG_STATE, 8'h05);
		wr(4'hF, 8'hAA);
		chkrd(`SPSM_REG_STATE, 8'h07, 8'h00);
		chkrd(4'hF, 8'hFF, 8'h00);
		$display("test interrupts done");
		final_report();
	end
endmodule // spsm_power_manager_tb
